/* File: hdl/ssp_params.svh */
// constants of the split-port synchronous sram
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH

// x36 organisation: two array halves of 2^20 words each
`define SSP_ADDR_W     20
`define SSP_DATA_W     36
`define SSP_LANE_W     9
`define SSP_LANES      4

// write command buffer
`define SSP_BUF_DEPTH  2
`define SSP_BUF_CNT_W  2

// reset values
`define SSP_RST_WORD   36'h000000000
`define SSP_RST_ADDR   20'h00000
`define SSP_RST_LANES  4'hF
`define SSP_RST_LINK   2'h3

// status bits carried to the system clock
`define SSP_STAT_W     3
`define SSP_STAT_RD    2
`define SSP_STAT_WR    1
`define SSP_STAT_OVF   0

`endif

/* File: hdl/ssp_pkg.sv */
// types shared by the split-port synchronous sram files
package ssp_pkg;

`include "ssp_params.svh"

typedef logic [`SSP_ADDR_W-1:0] ssp_addr_type;
typedef logic [`SSP_DATA_W-1:0] ssp_word_type;
typedef logic [`SSP_LANES-1:0]  ssp_lane_type;

// one complete two-word write, lane masks active high
typedef struct packed {
    ssp_addr_type addr;
    ssp_word_type word1;
    ssp_lane_type be1;
    ssp_word_type word0;
    ssp_lane_type be0;
} ssp_wcmd_type;

endpackage

/* File: hdl/ssp_sync2.sv */
// two flip-flop level synchroniser
`timescale 1ns/10ps
module ssp_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

/* File: hdl/ssp_two_buf.sv */
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`include "ssp_params.svh"
module ssp_two_buf #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         inValid,
    output logic              inReady,
    input  wire logic [W-1:0] inData,
    output logic              outValid,
    input  wire logic         outReady,
    output logic      [W-1:0] outData
);

    logic [W-1:0]              slot_reg [0:`SSP_BUF_DEPTH-1];
    logic                      wrPtr_reg;
    logic                      rdPtr_reg;
    logic [`SSP_BUF_CNT_W-1:0] count_reg;
    logic                      push;
    logic                      pop;

    assign inReady  = (count_reg != `SSP_BUF_CNT_W'(`SSP_BUF_DEPTH));
    assign outValid = (count_reg != `SSP_BUF_CNT_W'(0));
    assign outData  = slot_reg[rdPtr_reg];
    assign push     = inValid && inReady;
    assign pop      = outValid && outReady;

    always_ff @(posedge clk) begin
        if (push) begin
            slot_reg[wrPtr_reg] <= inData;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wrPtr_reg <= ~wrPtr_reg;
            end
            if (pop) begin
                rdPtr_reg <= ~rdPtr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + `SSP_BUF_CNT_W'(1);
            end else if (pop && !push) begin
                count_reg <= count_reg - `SSP_BUF_CNT_W'(1);
            end
        end
    end

endmodule

/* File: hdl/ssp_sram.sv */
// split-port synchronous sram: double-rate write and read ports on a shared address bus
//
// Operation
// - byte selects, active low, sampled on both input clock rises during a write
// - a high byte select leaves its stored lane untouched
// - select n governs the nine-bit lane n of the data word
// - byte selects are taken on the same edge as their data word
// - read address on positive input clock rise, write address on negative rise
// - two array halves addressed by twenty address bits in the x36 layout
// - address ignored on the edge of a port that is not selected
// - read data launched on rises of both output clock phases
// - single clock mode launches read data on the input clocks instead
// - read outputs are released while the read port is idle
// - low read select on positive input clock rise starts a read
// - a read already started completes after the port is deselected
// - drivers switch off after the next positive output clock rise
// - port selects are captured on the positive input clock rise
// - every access begins on a positive input clock rise
// - low write select on positive input clock rise starts a write
// - write data is taken on both input clock rises of a write
`timescale 1ns/10ps
`include "ssp_params.svh"
module ssp_sram
    import ssp_pkg::*;
(
    input  wire logic                  mclk,
    input  wire logic                  rst,
    input  wire logic                  kClk,
    input  wire logic                  kClkN,
    input  wire logic                  cClk,
    input  wire logic                  cClkN,
    input  wire logic                  singleClockMode,
    input  wire logic [`SSP_ADDR_W-1:0] addr,
    input  wire logic                  readPortSelectN,
    input  wire logic                  writePortSelectN,
    input  wire logic [`SSP_LANES-1:0] byteWriteSelectN,
    input  wire logic [`SSP_DATA_W-1:0] writeData,
    output logic      [`SSP_DATA_W-1:0] readDataRise,
    output logic      [`SSP_DATA_W-1:0] readDataFall,
    output logic                       readDataOe,
    output logic                       readBusy,
    output logic                       writeBusy,
    output logic                       writeOverflow
);

    // link reset: asserted at once, released on the positive input clock
    logic [1:0]    linkRstPipe_reg;
    logic          linkRst;

    // write capture
    logic          wrArm_reg;
    ssp_word_type  wrWord0_reg;
    ssp_lane_type  wrKeep0_reg;
    ssp_addr_type  wrAddr_reg;
    ssp_word_type  wrWord1_reg;
    ssp_lane_type  wrKeep1_reg;
    logic          wrSeq_reg;
    logic          wrSeen_reg;
    logic          newWrite;

    // command stage in front of the buffer
    ssp_wcmd_type  cmd_reg;
    logic          cmdPend_reg;
    logic          overflow_reg;
    logic          bufInReady;
    logic          bufOutValid;
    logic          bufOutReady;
    ssp_wcmd_type  bufOut;
    logic          drain;

    // read pipeline
    logic          rdPend_reg;
    ssp_addr_type  rdAddr_reg;
    logic          rdValid_reg;
    ssp_word_type  rdWord0_reg;
    ssp_word_type  rdWord1_reg;

    // array halves: first and second word of each burst
    ssp_word_type  memLow  [0:(1 << `SSP_ADDR_W)-1];
    ssp_word_type  memHigh [0:(1 << `SSP_ADDR_W)-1];

    // output launch clocks
    logic          qClkP;
    logic          qClkN;

    // reset release retimed onto each launch clock
    logic          launchRunP;
    logic          launchRunN;
    // second word kept from the first word's launch, so it never leaves first
    ssp_word_type  fallWord_reg;

    // status towards the system clock
    logic [`SSP_STAT_W-1:0] linkStatus_reg;
    logic [`SSP_STAT_W-1:0] sysStatus;

    always_ff @(posedge kClk or posedge rst) begin
        if (rst) begin
            linkRstPipe_reg <= `SSP_RST_LINK;
        end else begin
            linkRstPipe_reg <= {linkRstPipe_reg[0], 1'b0};
        end
    end

    assign linkRst = linkRstPipe_reg[1];

    // first half of a write: select, lane masks and first word on K rise
    always_ff @(posedge kClk or posedge linkRst) begin
        if (linkRst) begin
            wrArm_reg   <= 1'b0;
            wrWord0_reg <= `SSP_RST_WORD;
            wrKeep0_reg <= `SSP_RST_LANES;
        end else begin
            wrArm_reg <= !writePortSelectN;
            if (!writePortSelectN) begin
                wrWord0_reg <= writeData;
                wrKeep0_reg <= byteWriteSelectN;
            end
        end
    end

    // second half of a write: address, lane masks and second word on K-bar rise
    always_ff @(posedge kClkN or posedge linkRst) begin
        if (linkRst) begin
            wrAddr_reg  <= `SSP_RST_ADDR;
            wrWord1_reg <= `SSP_RST_WORD;
            wrKeep1_reg <= `SSP_RST_LANES;
            wrSeq_reg   <= 1'b0;
        end else if (wrArm_reg) begin
            wrAddr_reg  <= addr;
            wrWord1_reg <= writeData;
            wrKeep1_reg <= byteWriteSelectN;
            wrSeq_reg   <= ~wrSeq_reg;
        end
    end

    // a completed write shows as a change of the sequence bit at the next K rise
    assign newWrite = (wrSeq_reg != wrSeen_reg);

    // holds one complete write until the buffer takes it
    // with the stage held and the buffer full, a further completed write is dropped and flagged
    always_ff @(posedge kClk or posedge linkRst) begin
        if (linkRst) begin
            wrSeen_reg   <= 1'b0;
            cmdPend_reg  <= 1'b0;
            cmd_reg      <= '0;
            overflow_reg <= 1'b0;
        end else begin
            wrSeen_reg <= wrSeq_reg;
            if (newWrite && (!cmdPend_reg || bufInReady)) begin
                cmd_reg.addr  <= wrAddr_reg;
                cmd_reg.word0 <= wrWord0_reg;
                cmd_reg.be0   <= ~wrKeep0_reg;
                cmd_reg.word1 <= wrWord1_reg;
                cmd_reg.be1   <= ~wrKeep1_reg;
                cmdPend_reg   <= 1'b1;
            end else if (cmdPend_reg && bufInReady) begin
                cmdPend_reg <= 1'b0;
            end
            // sticky: a write arrived while the stage was still blocked
            if (newWrite && cmdPend_reg && !bufInReady) begin
                overflow_reg <= 1'b1;
            end
        end
    end

    ssp_two_buf #(
        .W ($bits(ssp_wcmd_type))
    ) u_wbuf (
        .clk      (kClk),
        .rst      (linkRst),
        .inValid  (cmdPend_reg),
        .inReady  (bufInReady),
        .inData   (cmd_reg),
        .outValid (bufOutValid),
        .outReady (bufOutReady),
        .outData  (bufOut)
    );

    // the array has one access per edge; a fetching read holds writes back
    // a read of an address still queued here returns the old contents
    assign bufOutReady = !rdPend_reg;
    assign drain       = bufOutValid && bufOutReady;

    always_ff @(posedge kClk) begin
        if (drain) begin
            for (int lane = 0; lane < `SSP_LANES; lane++) begin
                if (bufOut.be0[lane]) begin
                    memLow[bufOut.addr][lane*`SSP_LANE_W +: `SSP_LANE_W] <=
                        bufOut.word0[lane*`SSP_LANE_W +: `SSP_LANE_W];
                end
                if (bufOut.be1[lane]) begin
                    memHigh[bufOut.addr][lane*`SSP_LANE_W +: `SSP_LANE_W] <=
                        bufOut.word1[lane*`SSP_LANE_W +: `SSP_LANE_W];
                end
            end
        end
    end

    // read request: select and address on K rise, independent of the write port
    always_ff @(posedge kClk or posedge linkRst) begin
        if (linkRst) begin
            rdPend_reg <= 1'b0;
            rdAddr_reg <= `SSP_RST_ADDR;
        end else begin
            rdPend_reg <= !readPortSelectN;
            if (!readPortSelectN) begin
                rdAddr_reg <= addr;
            end
        end
    end

    // fetch one cycle later; runs regardless of the select now on the pin
    always_ff @(posedge kClk or posedge linkRst) begin
        if (linkRst) begin
            rdValid_reg <= 1'b0;
        end else begin
            rdValid_reg <= rdPend_reg;
        end
    end

    always_ff @(posedge kClk) begin
        if (rdPend_reg) begin
            rdWord0_reg <= memLow[rdAddr_reg];
            rdWord1_reg <= memHigh[rdAddr_reg];
        end
    end

    // output clock pair, or the input pair in single clock mode
    // the strap must stay put while the link is out of reset: the mux would glitch
    assign qClkP = singleClockMode ? kClk : cClk;
    assign qClkN = singleClockMode ? kClkN : cClkN;

    // the launch clocks run apart from the link clock, so their flops leave reset
    // two of their own edges after the link logic does
    ssp_sync2 #(
        .W (1)
    ) u_run_sync_p (
        .clk (qClkP),
        .rst (linkRst),
        .d   (1'b1),
        .q   (launchRunP)
    );

    ssp_sync2 #(
        .W (1)
    ) u_run_sync_n (
        .clk (qClkN),
        .rst (linkRst),
        .d   (1'b1),
        .q   (launchRunN)
    );

    // first word, the drive enable and a copy of the second word on the positive launch clock
    always_ff @(posedge qClkP or negedge launchRunP) begin
        if (!launchRunP) begin
            readDataOe   <= 1'b0;
            readDataRise <= `SSP_RST_WORD;
            fallWord_reg <= `SSP_RST_WORD;
        end else begin
            readDataOe <= rdValid_reg;
            if (rdValid_reg) begin
                readDataRise <= rdWord0_reg;
                fallWord_reg <= rdWord1_reg;
            end
        end
    end

    // second word only after its first word: in single clock mode the fetch is done
    // before a negative input clock rise that comes ahead of the first word's launch
    always_ff @(posedge qClkN or negedge launchRunN) begin
        if (!launchRunN) begin
            readDataFall <= `SSP_RST_WORD;
        end else if (readDataOe) begin
            readDataFall <= fallWord_reg;
        end
    end

    // registered levels so the synchroniser sees clean flop outputs
    always_ff @(posedge kClk or posedge linkRst) begin
        if (linkRst) begin
            linkStatus_reg <= '0;
        end else begin
            linkStatus_reg[`SSP_STAT_RD]  <= rdPend_reg || rdValid_reg;
            linkStatus_reg[`SSP_STAT_WR]  <= cmdPend_reg || bufOutValid;
            linkStatus_reg[`SSP_STAT_OVF] <= overflow_reg;
        end
    end

    ssp_sync2 #(
        .W (`SSP_STAT_W)
    ) u_stat_sync (
        .clk (mclk),
        .rst (rst),
        .d   (linkStatus_reg),
        .q   (sysStatus)
    );

    assign readBusy      = sysStatus[`SSP_STAT_RD];
    assign writeBusy     = sysStatus[`SSP_STAT_WR];
    assign writeOverflow = sysStatus[`SSP_STAT_OVF];

endmodule

/* File: tb/ssp_sram_props.sv */
// concurrent checks on the ports of the split-port sram
`timescale 1ns/10ps
`include "ssp_params.svh"
module ssp_sram_props (
    input wire logic                   mclk,
    input wire logic                   rst,
    input wire logic                   kClk,
    input wire logic                   readPortSelectN,
    input wire logic                   writePortSelectN,
    input wire logic [`SSP_DATA_W-1:0] readDataRise,
    input wire logic [`SSP_DATA_W-1:0] readDataFall,
    input wire logic                   readDataOe,
    input wire logic                   readBusy,
    input wire logic                   writeBusy,
    input wire logic                   writeOverflow
);
    property p_rd_oe;
        @(posedge kClk) disable iff (rst) !readPortSelectN |-> ##[2:3] readDataOe;
    endproperty
    a_rd_oe: assert property (p_rd_oe) else $error("read never drove outputs");
    property p_oe_idle;
        @(posedge kClk) disable iff (rst) readPortSelectN [*4] |-> !readDataOe;
    endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("outputs driven while idle");
    property p_hold;
        @(posedge kClk) disable iff (rst)
            readPortSelectN [*3] |=> $stable(readDataRise) && $stable(readDataFall);
    endproperty
    a_hold: assert property (p_hold) else $error("read data moved without read");
    property p_rise_oe;
        @(posedge kClk) disable iff (rst) $changed(readDataRise) |-> readDataOe;
    endproperty
    a_rise_oe: assert property (p_rise_oe) else $error("first word sent undriven");
    property p_fall_oe;
        @(posedge kClk) disable iff (rst) $changed(readDataFall) |-> readDataOe;
    endproperty
    a_fall_oe: assert property (p_fall_oe) else $error("second word sent undriven");
    property p_rd_busy;
        @(posedge mclk) disable iff (rst) $fell(readPortSelectN) |-> ##[1:40] readBusy;
    endproperty
    a_rd_busy: assert property (p_rd_busy) else $error("read not seen busy");
    property p_wr_busy;
        @(posedge mclk) disable iff (rst) $fell(writePortSelectN) |-> ##[1:40] writeBusy;
    endproperty
    a_wr_busy: assert property (p_wr_busy) else $error("write not seen busy");
    property p_ovf_sticky;
        @(posedge mclk) disable iff (rst) writeOverflow |=> writeOverflow;
    endproperty
    a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag dropped");
    property p_ovf_cause;
        @(posedge mclk) disable iff (rst) $rose(writeOverflow) |-> writeBusy;
    endproperty
    a_ovf_cause: assert property (p_ovf_cause) else $error("overflow, writes idle");
endmodule

bind ssp_sram ssp_sram_props u_ssp_sram_props (.mclk, .rst, .kClk, .readPortSelectN,
    .writePortSelectN, .readDataRise, .readDataFall, .readDataOe, .readBusy, .writeBusy,
    .writeOverflow);

/* File: tb/ssp_host_model.sv */
// host controller model: free-running link clocks and port requests
`timescale 1ns/10ps
module ssp_host_model
    import ssp_pkg::*;
(
    output logic         kClk,
    output logic         kClkN,
    output logic         cClk,
    output logic         cClkN,
    output ssp_addr_type addr,
    output logic         readPortSelectN,
    output logic         writePortSelectN,
    output ssp_lane_type byteWriteSelectN,
    output ssp_word_type writeData
);
    initial begin
        kClk = 1'b0;
        readPortSelectN = 1'b1;
        writePortSelectN = 1'b1;
        addr = 20'h5A5A5;
        byteWriteSelectN = 4'hF;
        writeData = 36'h0F0F0F0F0;
        #3;
        forever #40 kClk = ~kClk;
    end
    assign kClkN = ~kClk;
    // output clocks lag the input pair
    assign #10 cClk = kClk;
    assign #10 cClkN = ~kClk;
    // one cycle of requests; selects stay until the next call or idle
    task automatic access(input logic rd, input logic wr, input ssp_addr_type ra,
        input ssp_addr_type wa, input ssp_word_type w0, input ssp_word_type w1,
        input ssp_lane_type m0, input ssp_lane_type m1);
        readPortSelectN <= ~rd;
        writePortSelectN <= ~wr;
        addr <= ra;
        writeData <= w0;
        byteWriteSelectN <= m0;
        @(posedge kClk);
        addr <= wa;
        writeData <= w1;
        byteWriteSelectN <= m1;
        @(posedge kClkN);
    endtask
    // released lines change every cycle so stale values are never reused
    task automatic idle(input int n);
        readPortSelectN <= 1'b1;
        writePortSelectN <= 1'b1;
        repeat (n) begin
            addr <= ~addr;
            writeData <= ~writeData;
            byteWriteSelectN <= ~byteWriteSelectN;
            @(posedge kClk);
        end
    endtask
endmodule

/* File: tb/ssp_sram_bench.sv */
// self-checking bench of the split-port sram
`timescale 1ns/10ps
module ssp_sram_bench
    import ssp_pkg::*;
;
    logic         mclk, rst, singleClockMode, kClk, kClkN, cClk, cClkN;
    logic         readPortSelectN, writePortSelectN, readDataOe;
    logic         readBusy, writeBusy, writeOverflow;
    ssp_addr_type addr;
    ssp_lane_type byteWriteSelectN;
    ssp_word_type writeData, readDataRise, readDataFall, qPin;
    int           n_mismatch = 0;
    int           samples_checked = 0;

    assign qPin = readDataOe ? readDataRise : 36'hZZZZZZZZZ;
    always #4 mclk = ~mclk;

    ssp_sram u_ssp_sram (.mclk, .rst, .kClk, .kClkN, .cClk, .cClkN, .singleClockMode, .addr,
        .readPortSelectN, .writePortSelectN, .byteWriteSelectN, .writeData, .readDataRise,
        .readDataFall, .readDataOe, .readBusy, .writeBusy, .writeOverflow);
    ssp_host_model u_ssp_host_model (.kClk, .kClkN, .cClk, .cClkN, .addr, .readPortSelectN,
        .writePortSelectN, .byteWriteSelectN, .writeData);

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    function automatic ssp_word_type merge(input ssp_word_type old, input ssp_word_type nw,
        input ssp_lane_type selN);
        merge = old;
        for (int i = 0; i < 4; i++)
            if (!selN[i]) merge[9*i +: 9] = nw[9*i +: 9];
    endfunction
    task automatic end_sim;
        $display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // reset spans link clock rises as well
    task automatic do_reset(input logic mode);
        @(posedge mclk);
        rst <= 1'b1;
        singleClockMode <= mode;
        repeat (4) @(posedge mclk);
        repeat (2) @(posedge kClk);
        @(posedge mclk);
        rst <= 1'b0;
        u_ssp_host_model.idle(4);
    endtask
    task automatic wr(input ssp_addr_type a, input ssp_word_type w0, input ssp_word_type w1,
        input ssp_lane_type m0, input ssp_lane_type m1);
        u_ssp_host_model.access(1'b0, 1'b1, ~a, a, w0, w1, m0, m1);
        u_ssp_host_model.idle(4);
    endtask
    task automatic rd_chk(input ssp_addr_type a, input ssp_word_type e0, input ssp_word_type e1);
        u_ssp_host_model.access(1'b1, 1'b0, a, ~a, ~e0, ~e1, 4'h0, 4'h0);
        u_ssp_host_model.idle(5);
        check(readDataRise, e0);
        check(readDataFall, e1);
        check(qPin, 36'hZZZZZZZZZ);
        check(readBusy, 1'b0);
    endtask
    task automatic t_lanes;
        wr(20'hFFFFF, 36'h123456789, 36'hFEDCBA987, 4'h0, 4'h0);
        wr(20'hFFFFF, 36'hEDCBA9876, 36'h0F0F0F0F0, 4'hA, 4'h5);
        rd_chk(20'hFFFFF, merge(36'h123456789, 36'hEDCBA9876, 4'hA),
            merge(36'hFEDCBA987, 36'h0F0F0F0F0, 4'h5));
    endtask
    // read of one address and write of another in the same cycle
    task automatic t_conc;
        wr(20'h00002, 36'h111111111, 36'h222222222, 4'h0, 4'h0);
        u_ssp_host_model.access(1'b1, 1'b1, 20'h00002, 20'h00003, 36'h333333333,
            36'h444444444, 4'h0, 4'h0);
        u_ssp_host_model.idle(6);
        check(readDataRise, 36'h111111111);
        check(readDataFall, 36'h222222222);
        rd_chk(20'h00003, 36'h333333333, 36'h444444444);
        rd_chk(20'h00002, 36'h111111111, 36'h222222222);
    endtask
    // reads every cycle stall the drain until a write is dropped
    task automatic t_ovf;
        for (int i = 0; i < 6; i++)
            u_ssp_host_model.access(1'b1, 1'b1, 20'h00002, 20'h00100 + 20'(i),
                36'h0000001AB, 36'hABC000000, 4'h0, 4'h0);
        u_ssp_host_model.idle(8);
        check(writeOverflow, 1'b1);
        check(writeBusy, 1'b0);
        rd_chk(20'h00100, 36'h0000001AB, 36'hABC000000);
    endtask

    initial begin
        mclk = 1'b0;
        rst = 1'b1;
        singleClockMode = 1'b0;
        do_reset(1'b0);
        t_lanes;
        t_conc;
        t_ovf;
        do_reset(1'b1);
        check(writeOverflow, 1'b0);
        t_lanes;
        t_conc;
        end_sim;
    end
    initial begin
        #100000;
        n_mismatch++;
        end_sim;
    end
endmodule
